// [hms_pkg.sv]
/*
 * hms_pkg: constants and types shared by the homing method sequencer.
 * assumes: method numbers arrive as plain 8-bit binary values.
 */
package hms_pkg;
    localparam int POS_W = 32;
    localparam int METH_W = 8;
    localparam logic [7:0] METH_12 = 8'h0c;
    localparam logic [7:0] METH_13 = 8'h0d;
    localparam logic [7:0] METH_14 = 8'h0e;
    localparam logic [7:0] METH_17 = 8'h11;
    localparam logic [7:0] METH_18 = 8'h12;
    localparam logic [7:0] METH_19 = 8'h13;
    localparam logic [7:0] METH_20 = 8'h14;
    localparam logic [7:0] METH_21 = 8'h15;
    localparam logic [7:0] METH_RST = 8'h00;
    localparam logic [31:0] HOME_POS_RST = 32'h0000_0000;
    localparam logic SYNC_RST = 1'b0;

    typedef enum logic [1:0] {
        HMS_IDLE,
        HMS_SEEK,
        HMS_INDEX,
        HMS_DONE
    } hms_state_t;
endpackage

// [hms_pin_if.sv]
/*
 * hms_pin_if: one synchronised input pin with its edge strobes.
 * assumes: all users share clk_sys.
 */
interface hms_pin_if;
    logic lvl;
    logic rise;
    logic fall;
    modport src (output lvl, output rise, output fall);
    modport snk (input lvl, input rise, input fall);
endinterface

// [hms_pin_sync.sv]
/*
 * hms_pin_sync: two-flop synchroniser and edge detector for one pin.
 * assumes: pin is asynchronous to clk_sys; rst is synchronous.
 */
module hms_pin_sync (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic pin,
    hms_pin_if.src pin_o
);
    logic meta_r, meta_nxt;
    logic sync_r, sync_nxt;
    logic prev_r, prev_nxt;

    always_comb begin
        meta_nxt = pin;
        sync_nxt = meta_r;
        prev_nxt = sync_r;
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            meta_r <= hms_pkg::SYNC_RST;
            sync_r <= hms_pkg::SYNC_RST;
            prev_r <= hms_pkg::SYNC_RST;
        end else begin
            meta_r <= meta_nxt;
            sync_r <= sync_nxt;
            prev_r <= prev_nxt;
        end
    end

    // edges look only at the second and third flops, never at meta_r
    assign pin_o.lvl = sync_r;
    assign pin_o.rise = sync_r & ~prev_r;
    assign pin_o.fall = ~sync_r & prev_r;
endmodule

// [hms_top.sv]
/*
 * hms_top: homing sequencer for methods 12-14 and 17-21.
 * assumes: switch and index pins are asynchronous and active high;
 * position comes from logic on clk_sys; the motion loop outside
 * follows run_active, dir_positive and low_speed.
 */
module hms_top (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic start,
    input wire logic [7:0] method,
    input wire logic home_switch_input,
    input wire logic negative_travel_limit,
    input wire logic positive_travel_limit,
    input wire logic index_pulse,
    input wire logic [31:0] position,
    output logic run_active,
    output logic dir_positive,
    output logic low_speed,
    output logic [31:0] home_pos,
    output logic homing_done,
    output logic method_error
);
    hms_pin_if hsw_if ();
    hms_pin_if nl_if ();
    hms_pin_if pl_if ();
    hms_pin_if z_if ();

    hms_pin_sync u_hsw (
        .clk_sys(clk_sys),
        .rst(rst),
        .pin(home_switch_input),
        .pin_o(hsw_if)
    );
    hms_pin_sync u_nl (
        .clk_sys(clk_sys),
        .rst(rst),
        .pin(negative_travel_limit),
        .pin_o(nl_if)
    );
    hms_pin_sync u_pl (
        .clk_sys(clk_sys),
        .rst(rst),
        .pin(positive_travel_limit),
        .pin_o(pl_if)
    );
    hms_pin_sync u_z (
        .clk_sys(clk_sys),
        .rst(rst),
        .pin(index_pulse),
        .pin_o(z_if)
    );

    hms_pkg::hms_state_t state_r, state_nxt;
    logic [7:0] meth_r, meth_nxt;
    logic dir_r, dir_nxt;
    logic slow_r, slow_nxt;
    logic [31:0] home_r, home_nxt;
    logic err_r, err_nxt;
    logic known;
    logic take_start;
    logic finish;

    always_comb begin
        known = (method == hms_pkg::METH_12) || (method == hms_pkg::METH_13)
            || (method == hms_pkg::METH_14) || (method == hms_pkg::METH_17)
            || (method == hms_pkg::METH_18) || (method == hms_pkg::METH_19)
            || (method == hms_pkg::METH_20) || (method == hms_pkg::METH_21);
    end

    // a new start is taken only when no search is running
    assign take_start = start && (state_r == hms_pkg::HMS_IDLE
        || state_r == hms_pkg::HMS_DONE);

    always_comb begin
        state_nxt = state_r;
        meth_nxt = meth_r;
        dir_nxt = dir_r;
        slow_nxt = slow_r;
        home_nxt = home_r;
        err_nxt = err_r;
        finish = 1'b0;
        case (state_r)
            hms_pkg::HMS_IDLE, hms_pkg::HMS_DONE: begin
                if (take_start) begin
                    err_nxt = ~known;
                    slow_nxt = 1'b0;
                    meth_nxt = method;
                    if (known) begin
                        state_nxt = hms_pkg::HMS_SEEK;
                    end
                    case (method)
                        hms_pkg::METH_12: dir_nxt = hsw_if.lvl;
                        hms_pkg::METH_13: dir_nxt = 1'b0;
                        hms_pkg::METH_14: dir_nxt = 1'b0;
                        hms_pkg::METH_17: dir_nxt = 1'b0;
                        hms_pkg::METH_18: dir_nxt = 1'b1;
                        hms_pkg::METH_19: dir_nxt = ~hsw_if.lvl;
                        hms_pkg::METH_20: dir_nxt = ~hsw_if.lvl;
                        hms_pkg::METH_21: dir_nxt = hsw_if.lvl;
                        default: dir_nxt = dir_r;
                    endcase
                end
            end
            hms_pkg::HMS_SEEK: begin
                // travel limits turn the search around unless they are home
                if (dir_r && pl_if.rise && meth_r != hms_pkg::METH_18) begin
                    dir_nxt = 1'b0;
                end
                if (!dir_r && nl_if.rise && meth_r != hms_pkg::METH_17) begin
                    dir_nxt = 1'b1;
                end
                case (meth_r)
                    hms_pkg::METH_12: begin
                        if (hsw_if.rise) begin
                            state_nxt = hms_pkg::HMS_INDEX;
                            slow_nxt = 1'b1;
                            dir_nxt = 1'b0;
                        end
                    end
                    hms_pkg::METH_13: begin
                        if (dir_r && hsw_if.rise) begin
                            state_nxt = hms_pkg::HMS_INDEX;
                            slow_nxt = 1'b1;
                            dir_nxt = 1'b1;
                        end
                    end
                    hms_pkg::METH_14: begin
                        if (!dir_r && hsw_if.fall) begin
                            state_nxt = hms_pkg::HMS_INDEX;
                            slow_nxt = 1'b1;
                            dir_nxt = 1'b0;
                        end
                    end
                    hms_pkg::METH_17: begin
                        finish = !dir_r && nl_if.rise;
                    end
                    hms_pkg::METH_18: begin
                        finish = dir_r && pl_if.rise;
                    end
                    hms_pkg::METH_19, hms_pkg::METH_20: begin
                        // started on the switch: back off it, then return
                        finish = dir_r && hsw_if.rise;
                        if (!dir_r && hsw_if.fall) begin
                            dir_nxt = 1'b1;
                        end
                    end
                    hms_pkg::METH_21: begin
                        finish = !dir_r && hsw_if.rise;
                        if (dir_r && hsw_if.fall) begin
                            dir_nxt = 1'b0;
                        end
                    end
                    default: state_nxt = hms_pkg::HMS_IDLE;
                endcase
            end
            hms_pkg::HMS_INDEX: begin
                finish = z_if.rise;
            end
            default: state_nxt = hms_pkg::HMS_IDLE;
        endcase
        if (finish) begin
            state_nxt = hms_pkg::HMS_DONE;
            home_nxt = position;
            slow_nxt = 1'b0;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            state_r <= hms_pkg::HMS_IDLE;
            meth_r <= hms_pkg::METH_RST;
            dir_r <= 1'b0;
            slow_r <= 1'b0;
            home_r <= hms_pkg::HOME_POS_RST;
            err_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            meth_r <= meth_nxt;
            dir_r <= dir_nxt;
            slow_r <= slow_nxt;
            home_r <= home_nxt;
            err_r <= err_nxt;
        end
    end

    // position is caught three cycles after the pin edge, the sync cost
    assign run_active = (state_r == hms_pkg::HMS_SEEK)
        || (state_r == hms_pkg::HMS_INDEX);
    assign dir_positive = dir_r;
    assign low_speed = slow_r;
    assign home_pos = home_r;
    assign homing_done = (state_r == hms_pkg::HMS_DONE);
    assign method_error = err_r;

    property p_m12_start;
        @(posedge clk_sys) disable iff (rst)
        take_start && method == hms_pkg::METH_12
        |=> run_active && dir_positive == $past(hsw_if.lvl) && !low_speed;
    endproperty
    a_m12_start: assert property (p_m12_start)
        else $error("method 12 start direction wrong");

    property p_m12_slow;
        @(posedge clk_sys) disable iff (rst)
        state_r == hms_pkg::HMS_SEEK && meth_r == hms_pkg::METH_12
            && hsw_if.rise
        |=> state_r == hms_pkg::HMS_INDEX && low_speed && !dir_positive;
    endproperty
    a_m12_slow: assert property (p_m12_slow)
        else $error("method 12 did not slow toward negative index");

    property p_m13;
        @(posedge clk_sys) disable iff (rst)
        state_r == hms_pkg::HMS_SEEK && meth_r == hms_pkg::METH_13
            && dir_r && hsw_if.rise
        |=> low_speed && dir_positive ##0 !homing_done;
    endproperty
    a_m13: assert property (p_m13)
        else $error("method 13 did not slow forward");

    property p_m14;
        @(posedge clk_sys) disable iff (rst)
        state_r == hms_pkg::HMS_SEEK && meth_r == hms_pkg::METH_14
            && !dir_r && hsw_if.fall
        |=> state_r == hms_pkg::HMS_INDEX && low_speed && !dir_positive;
    endproperty
    a_m14: assert property (p_m14)
        else $error("method 14 did not slow on falling switch");

    property p_m17;
        @(posedge clk_sys) disable iff (rst)
        state_r == hms_pkg::HMS_SEEK && meth_r == hms_pkg::METH_17
            && !dir_r && nl_if.rise
        |=> homing_done && home_pos == $past(position) && !low_speed;
    endproperty
    a_m17: assert property (p_m17)
        else $error("method 17 missed negative limit home");

    property p_m18;
        @(posedge clk_sys) disable iff (rst)
        state_r == hms_pkg::HMS_SEEK && meth_r == hms_pkg::METH_18
            && dir_r && pl_if.rise
        |=> homing_done && home_pos == $past(position);
    endproperty
    a_m18: assert property (p_m18)
        else $error("method 18 missed positive limit home");

    property p_sw_fwd;
        @(posedge clk_sys) disable iff (rst)
        state_r == hms_pkg::HMS_SEEK && (meth_r == hms_pkg::METH_19
            || meth_r == hms_pkg::METH_20) && dir_r && hsw_if.rise
        |=> homing_done && !run_active && home_pos == $past(position)
            ##1 homing_done;
    endproperty
    a_sw_fwd: assert property (p_sw_fwd)
        else $error("switch home on forward travel missed");

    property p_m21;
        @(posedge clk_sys) disable iff (rst)
        state_r == hms_pkg::HMS_SEEK && meth_r == hms_pkg::METH_21
            && !dir_r && hsw_if.rise
        |=> homing_done && home_pos == $past(position);
    endproperty
    a_m21: assert property (p_m21)
        else $error("method 21 missed negative switch home");

    property p_index_home;
        @(posedge clk_sys) disable iff (rst)
        state_r == hms_pkg::HMS_INDEX && z_if.rise
        |=> homing_done && !run_active && home_pos == $past(position);
    endproperty
    a_index_home: assert property (p_index_home)
        else $error("index home not latched");

    c_index: cover property (@(posedge clk_sys) disable iff (rst)
        state_r == hms_pkg::HMS_INDEX ##1 homing_done);
    c_m17: cover property (@(posedge clk_sys) disable iff (rst)
        meth_r == hms_pkg::METH_17 && $rose(homing_done));
    c_err: cover property (@(posedge clk_sys) disable iff (rst)
        $rose(method_error));
endmodule

// [hms_motor_model.sv]
/*
 * hms_motor_model: behavioural motor, encoder and switch field.
 * assumes: one count every STEP cycles, longer than the pin latency.
 */
module hms_motor_model (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic run_active,
    input wire logic dir_positive,
    input wire logic load,
    input wire logic [31:0] load_val,
    output logic [31:0] position,
    output logic home_switch_input,
    output logic negative_travel_limit,
    output logic positive_travel_limit,
    output logic index_pulse
);
    localparam int STEP = 8;
    localparam int SW_LO = 100;
    localparam int SW_HI = 140;
    localparam int NL_AT = -200;
    localparam int PL_AT = 300;
    int div_r;

    // load lets the bench place the axis before a start
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            position <= 32'h0000_0000;
            div_r <= 0;
        end else if (load) begin
            position <= load_val;
            div_r <= 0;
        end else if (run_active) begin
            div_r <= (div_r == STEP - 1) ? 0 : div_r + 1;
            if (div_r == STEP - 1) begin
                position <= dir_positive ? position + 1 : position - 1;
            end
        end
    end

    // switches are zones of travel, index every 32 counts
    always_comb begin
        home_switch_input = ($signed(position) >= SW_LO) &&
            ($signed(position) <= SW_HI);
        negative_travel_limit = $signed(position) <= NL_AT;
        positive_travel_limit = $signed(position) >= PL_AT;
        index_pulse = (position[4:0] == 5'h00);
    end
endmodule

// [testbench.sv]
/*
 * testbench: self-checking bench for hms_top with a motor model.
 * assumes: switch zone 100..140, limits at -200 and 300, index each 32.
 */
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys = 1'b0, rst = 1'b1, start = 1'b0, load = 1'b0;
    logic seen_low = 1'b0;
    logic [7:0] method = 8'h00;
    logic [31:0] load_val = 32'h0000_0000;
    logic [31:0] position, home_pos;
    logic home_switch_input, negative_travel_limit;
    logic positive_travel_limit, index_pulse;
    logic run_active, dir_positive, low_speed, homing_done, method_error;
    int err_total = 0, checks_done = 0, cyc = 0;

    initial begin
        forever #2 clk_sys = ~clk_sys;
    end
    hms_motor_model i_hms_motor_model (.clk_sys, .rst, .run_active,
        .dir_positive, .load, .load_val, .position, .home_switch_input,
        .negative_travel_limit, .positive_travel_limit, .index_pulse);
    hms_top i_hms_top (.clk_sys, .rst, .start, .method, .home_switch_input,
        .negative_travel_limit, .positive_travel_limit, .index_pulse,
        .position, .run_active, .dir_positive, .low_speed, .home_pos,
        .homing_done, .method_error);

    task automatic results();
        $display("errors %0d checks %0d", err_total, checks_done);
        if (err_total == 0 && checks_done > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // the ceiling sits well above the longest search sequence
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (low_speed === 1'b1) begin
            seen_low <= 1'b1;
        end
        if (cyc == 60000) begin
            err_total++;
            $display("[FAIL] %0t run hung", $time);
            results();
        end
    end

    task automatic check(input logic [31:0] got, input logic [31:0] exp,
            input string what);
        checks_done++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] %0t %s got %0h exp %0h", $time, what, got, exp);
        end
    endtask

    task automatic kick(input logic [7:0] m);
        @(posedge clk_sys);
        seen_low <= 1'b0;
        start <= 1'b1;
        method <= m;
        @(posedge clk_sys);
        start <= 1'b0;
        repeat (2) @(posedge clk_sys);
        @(negedge clk_sys);
    endtask
    task automatic run_home(input logic [7:0] m, input logic [15:0] init,
            input logic exp_dir, input logic [15:0] exp_home);
        int n;
        logic [31:0] p;
        @(posedge clk_sys);
        load <= 1'b1;
        load_val <= 32'(signed'(init));
        @(posedge clk_sys);
        load <= 1'b0;
        // new pin levels must pass the synchronisers
        repeat (4) @(posedge clk_sys);
        kick(m);
        check(32'(run_active), 32'h0000_0001, "run");
        check(32'(dir_positive), 32'(exp_dir), "dir");
        check(32'(method_error), 32'h0000_0000, "error");
        n = 0;
        while (homing_done !== 1'b1 && n < 8000) begin
            @(negedge clk_sys);
            n++;
        end
        check(32'(homing_done), 32'h0000_0001, "done");
        check(home_pos, 32'(signed'(exp_home)), "home");
        check(32'(run_active), 32'h0000_0000, "stop");
        // only index methods creep
        check(32'(seen_low), 32'(m <= hms_pkg::METH_14), "creep");
        p = position;
        repeat (20) @(negedge clk_sys);
        check(position, p, "moved");
        check(32'(homing_done), 32'h0000_0001, "held");
    endtask

    task automatic t_m12();
        run_home(hms_pkg::METH_12, 16'h0000, 1'b0, 16'h0060);
        run_home(hms_pkg::METH_12, 16'h0078, 1'b1, 16'h0080);
    endtask
    task automatic t_index();
        run_home(hms_pkg::METH_13, 16'h0000, 1'b0, 16'h0080);
        run_home(hms_pkg::METH_14, 16'h0078, 1'b0, 16'h0060);
    endtask
    task automatic t_limit();
        run_home(hms_pkg::METH_17, 16'h0000, 1'b0, 16'hff38);
        run_home(hms_pkg::METH_18, 16'h0000, 1'b1, 16'h012c);
    endtask
    task automatic t_switch();
        run_home(hms_pkg::METH_19, 16'h0000, 1'b1, 16'h0064);
        run_home(hms_pkg::METH_20, 16'h0078, 1'b0, 16'h0064);
        run_home(hms_pkg::METH_21, 16'h0078, 1'b1, 16'h008c);
    endtask
    // refused start after a done
    task automatic t_bad_method();
        kick(8'h0f);
        check(32'(method_error), 32'h0000_0001, "bad flagged");
        check(32'(run_active), 32'h0000_0000, "bad ran");
        check(32'(homing_done), 32'h0000_0001, "done lost");
    endtask

    initial begin
        repeat (10) @(posedge clk_sys);
        rst <= 1'b0;
        t_m12();
        t_index();
        t_limit();
        t_bad_method();
        t_switch();
        results();
    end
endmodule
